/* logic/lim_regs.vh */
// Constants for the line interface mode and monitor block.
// Assumes a 20 MHz system clock; included by the design file only.
`ifndef LIM_REGS_VH
`define LIM_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LIM_CTRL_ADDR 4'h0
`define LIM_TXMODE_ADDR 4'h4
`define LIM_STATUS_ADDR 4'h8
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define LIM_F_RATE 0
`define LIM_F_CODING 1
`define LIM_F_NIBBLE 2
`define LIM_F_REFSEL_LO 3
`define LIM_F_REFSEL_HI 4
`define LIM_F_MON 5
`define LIM_F_LLBK 6
`define LIM_F_LOLRST 7
`define LIM_CTRL_RESET 8'h00
// ----------------------------------------
// Transmit mode register fields
// ----------------------------------------
`define LIM_F_SERIAL_TIMING_SELECT_LO 0
`define LIM_F_SERIAL_TIMING_SELECT_HI 1
`define LIM_F_NIBBLE_CLOCK_DIRECTION 2
`define LIM_F_FRST 3
`define LIM_TXMODE_RESET 4'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define LIM_CLK_HZ 20000000
`define LIM_LOS_UI 110
`define LIM_NRZ_WIN_UI 32
`define LIM_NRZ_MIN_TR 4
`define LIM_NRZ_LOS_NS 2300
`define LIM_NRZ_LOS_CYC ((`LIM_NRZ_LOS_NS * 20 + 999) / 1000)
`define LIM_LOL_SET_US 420
`define LIM_LOL_CLR_US 500
`define LIM_LOL_SET_CYC (`LIM_LOL_SET_US * 20)
`define LIM_LOL_CLR_CYC (`LIM_LOL_CLR_US * 20)
`define LIM_PPM_LIMIT 100
`define LIM_MEAS_CYC 16'd2000
`define LIM_EXP_UI_HIGH 16'd13926
`define LIM_EXP_UI_LOW 16'd15552
`endif

/* logic/lim_top.v */
// Mode decode, receive loss-of-signal and loss-of-lock monitor of a line interface.
// Assumes line-side strobes are slow relative to SYS_CLK_I; every control and line pin passes a
// two flip-flop synchroniser. Register access is AXI4-Lite, one word each.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lim_regs.vh"

// Function
// - Rate select 1 runs the PDH high rate, 0 the SDH rate.
// - Coding 1 enables coax encoder/decoder; 0 is NRZ pass-through.
// - Interface select picks nibble parallel or serial host interface.
// - Reference select 00, 10, 11 decode to reference frequency per rate. The code flags 10 at the high rate as a bad configuration.
// - Serial mode outputs recovered clock and data; parallel mode outputs nibbles.
// - Loss-of-signal detection disabled in receive monitor mode, coax only.
// - Coax loss-of-signal sets and clears after 110 unit intervals.
// - NRZ loss-of-signal sets after 2.3 us without transitions.
// - NRZ loss-of-signal clears on more than four transitions in 32 UI.
// - During loss-of-signal hold receive clock stable and data zero.
// - Loss-of-signal detection suppressed during local loopback.
// - Loss of lock flagged beyond 100 ppm for over 420 us.
// - Loss of lock clears after 500 us within 100 ppm.
// - Loss of lock undefined while loss-of-signal is present.
// - Serial timing 00 sync clk+data, 10 data only, 01 plesio, 11 loop.
// - Clock plus data mode captures on transmit clock rising edge, FIFO retimes.
// - Data-only mode recovers clock, uses FIFO, retimes with synthesized clock.
// - Plesiochronous mode recovers clock, bypasses FIFO and retiming.
// - Parallel mode retimes nibbles through a 4x8 FIFO then serialises.
// - Nibble clock direction 0 slave, 1 master.
// - Loop timing keeps FIFO and retimes with recovered receive clock.
// - Software select high uses registers; low uses the control pins.
// - FIFO slip sets error flag; FIFO reset clears it and recentres. The code only clears the flag and has no recentre output.
module lim_top (
  input wire SYS_CLK_I,
  input wire RST_I,
  input wire [3:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output wire S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output wire S_AXI_WREADY_O,
  output wire [1:0] S_AXI_BRESP_O,
  output wire S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [3:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output wire S_AXI_ARREADY_O,
  output wire [31:0] S_AXI_RDATA_O,
  output wire [1:0] S_AXI_RRESP_O,
  output wire S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  input wire SOFTWARE_CONTROL_SELECT_I,
  input wire HIGH_RATE_PDH_SELECT_I,
  input wire COAX_CODING_SELECT_I,
  input wire NIBBLE_INTERFACE_SELECT_I,
  input wire [1:0] REF_FREQ_SELECT_I,
  input wire RX_FLAT_GAIN_ENABLE_I,
  input wire LOCAL_LOOPBACK_I,
  input wire [1:0] TX_TIMING_PIN_I,
  input wire LINE_UI_CLK_I,
  input wire LINE_PEAK_LOW_I,
  input wire LINE_PEAK_HIGH_I,
  input wire LINE_RX_DATA_I,
  input wire FIFO_SLIP_I,
  output reg RX_SIGNAL_LOST_O,
  output reg RX_LOCK_LOST_O,
  output reg RX_DATA_O,
  output reg [3:0] RX_NIBBLE_O,
  output reg RX_CLK_HOLD_O,
  output reg FIFO_SLIP_ERROR_O,
  output reg [15:0] MODE_O
);

  // ----------------------------------------
  // Mode output bit positions
  // ----------------------------------------
  localparam M_HIGH_RATE = 0;
  localparam M_CODEC_EN = 1;
  localparam M_NIBBLE = 2;
  localparam M_TX_CDR = 3;
  localparam M_FIFO_EN = 4;
  localparam M_RETIME_SYN = 5;
  localparam M_RETIME_RX = 6;
  localparam M_CAPT_CLK = 7;
  localparam M_MASTER = 8;
  localparam M_REF_LO = 9;
  localparam M_REF_MID = 10;
  localparam M_REF_HI = 11;
  localparam M_CFG_BAD = 12;
  localparam M_RX_SERIAL = 13;

  localparam [1:0] T_SYNC_CD = 2'b00;
  localparam [1:0] T_PLESIO = 2'b01;
  localparam [1:0] T_SYNC_D = 2'b10;
  localparam [1:0] T_LOOP = 2'b11;

  localparam [15:0] LOS_SET_UI = `LIM_LOS_UI;
  localparam [15:0] NRZ_LOS_CYC = `LIM_NRZ_LOS_CYC;
  localparam [17:0] LOL_SET_CYC = `LIM_LOL_SET_CYC;
  localparam [17:0] LOL_CLR_CYC = `LIM_LOL_CLR_CYC;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam NSYNC = 16;
  wire [NSYNC-1:0] raw_w;
  reg [NSYNC-1:0] s1_q;
  reg [NSYNC-1:0] s2_q;
  assign raw_w = {SOFTWARE_CONTROL_SELECT_I, HIGH_RATE_PDH_SELECT_I, COAX_CODING_SELECT_I,
                  NIBBLE_INTERFACE_SELECT_I, REF_FREQ_SELECT_I, RX_FLAT_GAIN_ENABLE_I,
                  LOCAL_LOOPBACK_I, TX_TIMING_PIN_I, LINE_UI_CLK_I, LINE_PEAK_LOW_I,
                  LINE_PEAK_HIGH_I, LINE_RX_DATA_I, FIFO_SLIP_I, 1'b0};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw_w[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate
  wire sw_sel = s2_q[15];
  wire ui_clk = s2_q[5];
  wire peak_low = s2_q[4];
  wire peak_high = s2_q[3];
  wire rx_bit = s2_q[2];
  wire slip = s2_q[1];

  // ----------------------------------------
  // Register file and AXI4-Lite slave
  // ----------------------------------------
  reg [7:0] ctrl_q;
  reg [3:0] txmode_q;
  reg aw_q, w_q, bvalid_q, rvalid_q;
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [1:0] bresp_q, rresp_q;
  reg [31:0] rdata_q;
  wire [31:0] status_w;

  function addr_ok;
    input [3:0] a;
    begin
      addr_ok = (a == `LIM_CTRL_ADDR) || (a == `LIM_TXMODE_ADDR) || (a == `LIM_STATUS_ADDR);
    end
  endfunction

  assign S_AXI_AWREADY_O = !aw_q && !bvalid_q;
  assign S_AXI_WREADY_O = !w_q && !bvalid_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = !rvalid_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;

  wire do_write = aw_q && w_q && !bvalid_q;
  wire frst_pulse = do_write && (awaddr_q == `LIM_TXMODE_ADDR) && wstrb_q[0]
                    && wdata_q[`LIM_F_FRST];

  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bresp_q <= 2'h0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
      ctrl_q <= `LIM_CTRL_RESET;
      txmode_q <= `LIM_TXMODE_RESET;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_q <= 1'b1;
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(awaddr_q) ? 2'h0 : 2'h2;
        if (wstrb_q[0] && awaddr_q == `LIM_CTRL_ADDR)
          ctrl_q <= wdata_q[7:0];
        if (wstrb_q[0] && awaddr_q == `LIM_TXMODE_ADDR)
          txmode_q <= {1'b0, wdata_q[2:0]};
      end else if (bvalid_q && S_AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
      end
      if (S_AXI_ARVALID_I && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= addr_ok(S_AXI_ARADDR_I) ? 2'h0 : 2'h2;
        case (S_AXI_ARADDR_I)
          `LIM_CTRL_ADDR: rdata_q <= {24'h0, ctrl_q};
          `LIM_TXMODE_ADDR: rdata_q <= {28'h0, txmode_q};
          `LIM_STATUS_ADDR: rdata_q <= status_w;
          default: rdata_q <= 32'h0;
        endcase
      end else if (rvalid_q && S_AXI_RREADY_I) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Configuration source and mode decode
  // ----------------------------------------
  // Pins or registers.
  wire high_rate = sw_sel ? ctrl_q[`LIM_F_RATE] : s2_q[14];
  wire coax = sw_sel ? ctrl_q[`LIM_F_CODING] : s2_q[13];
  wire nibble = sw_sel ? ctrl_q[`LIM_F_NIBBLE] : s2_q[12];
  wire [1:0] refsel = sw_sel ? {ctrl_q[`LIM_F_REFSEL_HI], ctrl_q[`LIM_F_REFSEL_LO]}
                             : s2_q[11:10];
  wire mon = sw_sel ? ctrl_q[`LIM_F_MON] : s2_q[9];
  wire llbk = sw_sel ? ctrl_q[`LIM_F_LLBK] : s2_q[8];
  wire lol_rst = sw_sel & ctrl_q[`LIM_F_LOLRST];
  // Pin code 2'b01 also selects nibble clock master; pins follow the same encoding as the register field.
  wire [1:0] tmode = sw_sel ? txmode_q[1:0] : s2_q[7:6];
  wire nibble_clock_direction = sw_sel ? txmode_q[`LIM_F_NIBBLE_CLOCK_DIRECTION] : (s2_q[7:6] == 2'b01);

  // Decoded mode image, registered so data outputs come from flip-flops.
  reg [15:0] mode_d;
  always @* begin
    mode_d = 16'h0000;
    mode_d[M_HIGH_RATE] = high_rate;
    mode_d[M_CODEC_EN] = coax;
    mode_d[M_NIBBLE] = nibble;
    mode_d[M_RX_SERIAL] = !nibble;
    mode_d[M_REF_LO] = (refsel == 2'b00);
    mode_d[M_REF_MID] = (refsel == 2'b10) && !high_rate;
    mode_d[M_REF_HI] = (refsel == 2'b11);
    mode_d[M_CFG_BAD] = (refsel == 2'b01) || ((refsel == 2'b10) && high_rate);
    // Serial timing decode; loop timing holds for either interface.
    if (tmode == T_LOOP) begin
      mode_d[M_FIFO_EN] = 1'b1;
      mode_d[M_RETIME_RX] = 1'b1;
      mode_d[M_MASTER] = nibble & nibble_clock_direction;
    end else if (nibble) begin
      mode_d[M_FIFO_EN] = 1'b1;
      mode_d[M_RETIME_SYN] = 1'b1;
      mode_d[M_MASTER] = nibble_clock_direction;
    end else begin
      case (tmode)
        T_SYNC_CD: begin
          mode_d[M_CAPT_CLK] = 1'b1;
          mode_d[M_FIFO_EN] = 1'b1;
          mode_d[M_RETIME_SYN] = 1'b1;
        end
        T_SYNC_D: begin
          mode_d[M_TX_CDR] = 1'b1;
          mode_d[M_FIFO_EN] = 1'b1;
          mode_d[M_RETIME_SYN] = 1'b1;
        end
        T_PLESIO: mode_d[M_TX_CDR] = 1'b1;
        default: mode_d[M_TX_CDR] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Receive loss-of-signal
  // ----------------------------------------
  reg ui_prev_q, bit_prev_q, los_q;
  reg [15:0] below_q, above_q, quiet_q;
  reg [31:0] win_q;
  wire ui_rise = ui_clk && !ui_prev_q;
  wire bit_tr = ui_rise && (rx_bit != bit_prev_q);
  wire los_en = !llbk && !(coax && mon);

  function [5:0] popcount;
    input [31:0] v;
    integer k;
    begin
      popcount = 6'd0;
      for (k = 0; k < 32; k = k + 1)
        popcount = popcount + {5'd0, v[k]};
    end
  endfunction

  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ui_prev_q <= 1'b0;
      bit_prev_q <= 1'b0;
      los_q <= 1'b0;
      below_q <= 16'h0;
      above_q <= 16'h0;
      quiet_q <= 16'h0;
      win_q <= 32'h0;
    end else begin
      ui_prev_q <= ui_clk;
      if (ui_rise) begin
        bit_prev_q <= rx_bit;
        win_q <= {win_q[30:0], bit_tr};
      end
      quiet_q <= (bit_tr || !los_en || coax) ? 16'h0 :
                 (quiet_q == NRZ_LOS_CYC ? quiet_q : quiet_q + 16'd1);
      if (ui_rise) begin
        below_q <= peak_low ? (below_q == LOS_SET_UI ? below_q : below_q + 16'd1) : 16'h0;
        above_q <= peak_high ? (above_q == LOS_SET_UI ? above_q : above_q + 16'd1) : 16'h0;
      end
      if (!los_en) begin
        los_q <= 1'b0;
      end else if (coax) begin
        if (below_q == LOS_SET_UI)
          los_q <= 1'b1;
        else if (above_q == LOS_SET_UI)
          los_q <= 1'b0;
      end else begin
        if (quiet_q == NRZ_LOS_CYC)
          los_q <= 1'b1;
        else if (popcount(win_q) > `LIM_NRZ_MIN_TR)
          los_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Receive loss-of-lock
  // ----------------------------------------
  // Frequency is compared by counting UI edges over a fixed gate of system cycles
  // against the count expected for the selected rate; tolerance is 100 ppm.
  reg [15:0] gate_q, ui_cnt_q, meas_q;
  reg meas_v_q, off_q, lol_q;
  reg [17:0] off_t_q, on_t_q;
  wire [15:0] exp_w = MODE_O[M_HIGH_RATE] ? `LIM_EXP_UI_HIGH : `LIM_EXP_UI_LOW;
  wire [15:0] diff_w = (meas_q > exp_w) ? meas_q - exp_w : exp_w - meas_q;
  // The tolerance is divided out first, so the product never overflows 32 bits.
  wire [31:0] lhs_w = {16'h0, diff_w} * (32'd1000000 / `LIM_PPM_LIMIT);
  wire [31:0] rhs_w = {16'h0, exp_w};

  always @(posedge SYS_CLK_I) begin
    if (RST_I || lol_rst) begin
      gate_q <= 16'h0;
      ui_cnt_q <= 16'h0;
      meas_q <= 16'h0;
      meas_v_q <= 1'b0;
      off_q <= 1'b0;
      lol_q <= 1'b0;
      off_t_q <= 18'h0;
      on_t_q <= 18'h0;
    end else begin
      meas_v_q <= 1'b0;
      if (gate_q == `LIM_MEAS_CYC - 16'd1) begin
        gate_q <= 16'h0;
        meas_q <= ui_cnt_q + {15'h0, ui_rise};
        ui_cnt_q <= 16'h0;
        meas_v_q <= 1'b1;
      end else begin
        gate_q <= gate_q + 16'd1;
        ui_cnt_q <= ui_cnt_q + {15'h0, ui_rise};
      end
      if (meas_v_q)
        off_q <= (lhs_w > rhs_w);
      off_t_q <= off_q ? (off_t_q > LOL_SET_CYC ? off_t_q : off_t_q + 18'd1) : 18'h0;
      on_t_q <= !off_q ? (on_t_q > LOL_CLR_CYC ? on_t_q : on_t_q + 18'd1) : 18'h0;
      if (off_t_q > LOL_SET_CYC)
        lol_q <= 1'b1;
      else if (on_t_q > LOL_CLR_CYC)
        lol_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // FIFO error and outputs
  // ----------------------------------------
  reg [3:0] nib_q;
  reg [1:0] nib_cnt_q;
  assign status_w = {25'h0, MODE_O[M_CFG_BAD], FIFO_SLIP_ERROR_O, RX_LOCK_LOST_O,
                     RX_SIGNAL_LOST_O, sw_sel, MODE_O[M_FIFO_EN], MODE_O[M_TX_CDR]};

  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      RX_SIGNAL_LOST_O <= 1'b0;
      RX_LOCK_LOST_O <= 1'b0;
      RX_DATA_O <= 1'b0;
      RX_NIBBLE_O <= 4'h0;
      RX_CLK_HOLD_O <= 1'b0;
      FIFO_SLIP_ERROR_O <= 1'b0;
      MODE_O <= 16'h0;
      nib_q <= 4'h0;
      nib_cnt_q <= 2'h0;
    end else begin
      MODE_O <= mode_d;
      RX_SIGNAL_LOST_O <= los_q;
      // Lock flag is a don't-care during loss of signal; it is passed as is.
      RX_LOCK_LOST_O <= lol_q;
      // Slip sets; the set wins over a coincident reset.
      if (slip && MODE_O[M_FIFO_EN])
        FIFO_SLIP_ERROR_O <= 1'b1;
      else if (frst_pulse)
        FIFO_SLIP_ERROR_O <= 1'b0;
      RX_CLK_HOLD_O <= los_q;
      if (los_q) begin
        RX_DATA_O <= 1'b0;
        RX_NIBBLE_O <= 4'h0;
        nib_cnt_q <= 2'h0;
      end else if (ui_rise) begin
        RX_DATA_O <= rx_bit;
        nib_q <= {nib_q[2:0], rx_bit};
        nib_cnt_q <= nib_cnt_q + 2'd1;
        if (nib_cnt_q == 2'd3 && MODE_O[M_NIBBLE])
          RX_NIBBLE_O <= {nib_q[2:0], rx_bit};
      end
    end
  end

endmodule // lim_top

/* verif/lim_top_assertions.sv */
// Checker of the line interface mode and monitor block, on its top ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module lim_top_assertions (
  input wire SYS_CLK_I,
  input wire RST_I,
  input wire S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [1:0] S_AXI_BRESP_O,
  input wire S_AXI_ARVALID_I,
  input wire S_AXI_ARREADY_O,
  input wire [3:0] S_AXI_ARADDR_I,
  input wire S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  input wire [31:0] S_AXI_RDATA_O,
  input wire [1:0] S_AXI_RRESP_O,
  input wire SOFTWARE_CONTROL_SELECT_I,
  input wire COAX_CODING_SELECT_I,
  input wire RX_FLAT_GAIN_ENABLE_I,
  input wire LOCAL_LOOPBACK_I,
  input wire RX_SIGNAL_LOST_O,
  input wire RX_DATA_O,
  input wire [3:0] RX_NIBBLE_O,
  input wire RX_CLK_HOLD_O,
  input wire [15:0] MODE_O
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  a_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write answer dropped");
  a_rvalid_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read answer dropped");
  a_rd_unmapped: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == 4'hc
    |=> S_AXI_RVALID_O && S_AXI_RRESP_O == 2'h2 && S_AXI_RDATA_O == 32'h0)
    else $error("unmapped read not refused");
  a_los_squelch: assert property (
    RX_SIGNAL_LOST_O && $past(RX_SIGNAL_LOST_O) && $past(RX_SIGNAL_LOST_O, 2)
    |-> !RX_DATA_O && RX_NIBBLE_O == 4'h0 && RX_CLK_HOLD_O) else $error("data not squelched");
  a_loop_nolos: assert property (
    (LOCAL_LOOPBACK_I && !SOFTWARE_CONTROL_SELECT_I) [*8] |-> !RX_SIGNAL_LOST_O)
    else $error("loss of signal in loopback");
  a_mon_nolos: assert property (
    (COAX_CODING_SELECT_I && RX_FLAT_GAIN_ENABLE_I && !SOFTWARE_CONTROL_SELECT_I) [*8]
    |-> !RX_SIGNAL_LOST_O) else $error("loss of signal in monitor mode");
  a_plesio_bypass: assert property (!MODE_O[4] |-> !MODE_O[5] && !MODE_O[6])
    else $error("retiming without fifo");
  a_loop_retime: assert property (MODE_O[6] |-> MODE_O[4] && !MODE_O[5])
    else $error("loop timing path wrong");
  a_capture_clk: assert property (MODE_O[7] |-> MODE_O[4] && MODE_O[5] && !MODE_O[3])
    else $error("clock plus data path wrong");
  a_ref_mid: assert property (MODE_O[10] |-> !MODE_O[0] && !MODE_O[12])
    else $error("mid reference at high rate");
endmodule // lim_top_assertions

bind lim_top lim_top_assertions u_lim_chk (.*);

/* verif/lim_line_model.sv */
// Line-side model: unit-interval strobe, peak detectors and received data.
// Assumes the bench raises quiet_i to take the signal away.
`timescale 1ns/1ps
module lim_line_model (
  input wire logic quiet_i,
  output logic ui_clk_o,
  output logic peak_low_o,
  output logic peak_high_o,
  output logic data_o
);
  // The strobe runs free with its own phase, as a line clock does.
  initial begin
    ui_clk_o = 1'b0;
    #13;
    forever #200 ui_clk_o = ~ui_clk_o;
  end
  assign peak_low_o = quiet_i;
  assign peak_high_o = ~quiet_i;
  initial data_o = 1'b0;
  always @(negedge ui_clk_o) begin
    if (!quiet_i) begin
      data_o <= ~data_o;
    end
  end
endmodule // lim_line_model

/* verif/lim_top_test.sv */
// Self-checking bench of the line interface mode and monitor block.
// Assumes a 20 MHz clock and the line model on the receive pins.
`timescale 1ns/1ps
module lim_top_test;
  logic clk = 0, rst = 1, sw = 1, rate = 0, coax = 0, nib = 0, mon = 0, llb = 0;
  logic slip = 0, quiet = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [1:0] refp = 0, tmp = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
  logic [31:0] wdata = 0;
  wire awrdy, wrdy, bvalid, arrdy, rvalid, los, lol, rxd, hold, fifo_slip_error, uic, pl, ph, ld;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] nibo;
  wire [15:0] mode;
  int fail_count = 0, n_tests = 0;
  logic [3:0] tx_e [4] = '{4'b1011, 4'b0000, 4'b0011, 4'b0101};
  always #25 clk = ~clk;
  // The framer side is ideal: its transmit clock would share this reference.
  lim_line_model u_line (.quiet_i(quiet), .ui_clk_o(uic), .peak_low_o(pl),
    .peak_high_o(ph), .data_o(ld));
  lim_top dut (.SYS_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .SOFTWARE_CONTROL_SELECT_I(sw),
    .HIGH_RATE_PDH_SELECT_I(rate), .COAX_CODING_SELECT_I(coax),
    .NIBBLE_INTERFACE_SELECT_I(nib), .REF_FREQ_SELECT_I(refp),
    .RX_FLAT_GAIN_ENABLE_I(mon), .LOCAL_LOOPBACK_I(llb), .TX_TIMING_PIN_I(tmp),
    .LINE_UI_CLK_I(uic), .LINE_PEAK_LOW_I(pl), .LINE_PEAK_HIGH_I(ph),
    .LINE_RX_DATA_I(ld), .FIFO_SLIP_I(slip), .RX_SIGNAL_LOST_O(los),
    .RX_LOCK_LOST_O(lol), .RX_DATA_O(rxd), .RX_NIBBLE_O(nibo),
    .RX_CLK_HOLD_O(hold), .FIFO_SLIP_ERROR_O(fifo_slip_error), .MODE_O(mode));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ends on a falling edge, so outputs are settled when compared.
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, pb, ka, kw, kb;
    logic [1:0] rs;
    pa = 1;
    pw = 1;
    pb = 1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    while (pb) begin
      @(negedge clk);
      ka = pa && awrdy;
      kw = pw && wrdy;
      kb = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ka) begin awv <= 0; pa = 0; end
      if (kw) begin wv <= 0; pw = 0; end
      if (kb) begin bready <= 0; pb = 0; chk("bresp", er, rs); end
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    logic pa, ka, kr;
    logic [1:0] rs;
    pa = 1;
    kr = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    while (!kr) begin
      @(negedge clk);
      ka = pa && arrdy;
      kr = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge clk);
      if (ka) begin arv <= 0; pa = 0; end
      if (kr) rready <= 0;
    end
    chk("rresp", er, rs);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [1:0] er, input logic [31:0] e);
    logic [31:0] d;
    rd(a, er, d);
    chk("rdata", e, d);
  endtask
  task automatic los_wait(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (los !== v && n < hi + 10);
    chk("los_time", 1, n >= lo && n <= hi);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdc(4'h0, 0, 0);
    rdc(4'h4, 0, 0);
    rdc(4'hc, 2, 0);
    wr(4'h0, 32'hffff_ffd5, 0);
    rdc(4'h0, 0, 32'hd5);
    wstrb <= 4'he;
    wr(4'h0, 32'h0, 0);
    rdc(4'h0, 0, 32'hd5);
    wstrb <= 4'hf;
    wr(4'h4, 32'hf, 0);
    rdc(4'h4, 0, 32'h7);
    wr(4'hc, 32'h1, 2);
    $display("done regs");
  endtask
  task automatic t_modes;
    wr(4'h0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, i, 0);
      cyc(4);
      chk("tx_mode", tx_e[i], mode[7:4]);
      chk("rx_serial", 1, mode[13]);
      if (i != 0 && i != 3) chk("tx_cdr", 1, mode[3]);
    end
    for (int r = 0; r < 2; r++) for (int c = 0; c < 4; c++) begin
      wr(4'h0, c * 8 + r + c[0] * 2, 0);
      cyc(4);
      chk("rate_coax", {c[0], r[0]}, mode[1:0]);
      if (c == 1 || (c == 2 && r == 1)) chk("bad_cfg", 1, mode[12]);
      else chk("ref_sel", {1'b0, c == 3, c == 2, c == 0}, mode[12:9]);
    end
    for (int p = 0; p < 2; p++) begin
      wr(4'h0, 4, 0);
      wr(4'h4, p * 4, 0);
      cyc(4);
      chk("nibble", {1'b0, p[0], 2'b11}, {mode[13], mode[8], mode[4], mode[2]});
    end
    $display("done modes");
  endtask
  task automatic t_pins;
    @(posedge clk);
    sw <= 0;
    rate <= 1;
    coax <= 1;
    mon <= 1;
    llb <= 1;
    refp <= 3;
    tmp <= 1;
    cyc(12);
    chk("pin_mode", 5'b10111, {mode[11], mode[4:3], mode[1:0]});
    chk("los_off", 0, los);
    @(posedge clk);
    sw <= 1;
    mon <= 0;
    llb <= 0;
    $display("done pins");
  endtask
  task automatic t_nrz;
    wr(4'h0, 0, 0);
    wr(4'h4, 0, 0);
    cyc(40);
    chk("los", 0, los);
    @(posedge clk);
    quiet <= 1;
    los_wait(1, 38, 62);
    cyc(3);
    chk("squelch", 6'h20, {hold, rxd, nibo});
    @(posedge clk);
    quiet <= 0;
    los_wait(0, 1, 320);
    $display("done nrz");
  endtask
  task automatic t_coax;
    wr(4'h0, 2, 0);
    cyc(900);
    @(posedge clk);
    quiet <= 1;
    los_wait(1, 800, 944);
    @(posedge clk);
    quiet <= 0;
    los_wait(0, 800, 944);
    for (int k = 0; k < 2; k++) begin
      wr(4'h0, k ? 32'h42 : 32'h22, 0);
      @(posedge clk);
      quiet <= 1;
      cyc(1000);
      chk("los_off", 0, los);
      @(posedge clk);
      quiet <= 0;
    end
    $display("done coax");
  endtask
  task automatic t_fifo;
    logic [31:0] d;
    wr(4'h0, 0, 0);
    for (int i = 0; i < 2; i++) begin
      wr(4'h4, i, 0);
      @(posedge clk);
      slip <= 1;
      cyc(3);
      @(posedge clk);
      slip <= 0;
      cyc(6);
      chk("fifo_slip_error", i == 0, fifo_slip_error);
      rd(4'h8, 0, d);
      chk("stat_fifo_slip_error", i == 0, d[5]);
      wr(4'h4, 8 + i, 0);
      cyc(4);
      chk("fifo_slip_error_clr", 0, fifo_slip_error);
    end
    $display("done fifo");
  endtask
  task automatic t_lol;
    int n;
    n = 0;
    wr(4'h4, 0, 0);
    wr(4'h0, 32'h80, 0);
    cyc(20);
    chk("lol_rst", 0, lol);
    wr(4'h0, 0, 0);
    do begin @(negedge clk); n++; end while (lol !== 1 && n < 16000);
    chk("lol_time", 1, n > 8400 && n < 16000);
    wr(4'h0, 32'h80, 0);
    cyc(10);
    chk("lol_clr", 0, lol);
    $display("done lol");
  endtask
  // ----------------------------------------
  // Run
  // ----------------------------------------
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs;
    t_modes;
    t_pins;
    t_nrz;
    t_coax;
    t_fifo;
    t_lol;
    results;
  end
  // A hang counts as a mismatch; the tests need about 16000 cycles.
  initial begin
    #(40000 * 50);
    fail_count++;
    results;
  end
endmodule // lim_top_test
